// >>> core/ilb_core.sv
// How it works
// - and_immediate ands immediate into destination
// - status_word and only in supervisor, else trap
// - arithmetic shifts store shifted destination
// - taken branch loads pc plus displacement
// - bit_test_invert puts inverse bit in zero
// - field_invert complements field, keeps other bits
// - field extract delivers field to data_register
`timescale 1ns/10ps
`default_nettype none
module ilb_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // operation request
  input wire logic op_valid,
  input wire ilb_pkg::ilb_op_e op,
  input wire logic [31:0] op_dst,
  input wire logic [31:0] op_src,
  input wire logic [5:0] op_count,
  input wire logic [3:0] op_cond,
  input wire logic [31:0] op_pc,
  input wire logic [31:0] op_disp,
  input wire logic [4:0] op_offset,
  input wire logic [4:0] op_width,
  // operation answer
  output logic res_valid,
  output logic res_wr,
  output logic [31:0] res_data,
  output logic pc_load,
  output logic [31:0] pc_next,
  output logic trap,
  output logic [15:0] status_word,
  // register port
  input wire logic [ilb_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // interrupt
  output logic irq
);
  import ilb_pkg::*;

  typedef struct packed {
    logic ctrl_en;
    logic [15:0] sw;
    logic [EV_W-1:0] ev_stat;
    logic [EV_W-1:0] ev_en;
    logic res_valid;
    logic res_wr;
    logic [31:0] res_data;
    logic pc_load;
    logic [31:0] pc_next;
    logic trap;
    logic [31:0] rdata;
    logic irq;
  } ilb_state_s;

  ilb_state_s s_reg;
  ilb_state_s s_next;

  ilb_fld_if fld ();
  logic cond_true;
  logic go;
  logic [63:0] shl_t;
  logic [63:0] shr_t;
  logic [31:0] bit_sel;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] ev_clr;

  ilb_field_unit u_field (
    .fld(fld)
  );

  ilb_cond_eval u_cond (
    .cond(op_cond),
    .nzvc(s_reg.sw[FL_N:FL_C]),
    .taken(cond_true)
  );

  assign fld.data = op_dst;
  assign fld.offset = op_offset;
  assign fld.width = op_width;
  assign go = op_valid && s_reg.ctrl_en;

  always_comb begin
    s_next = s_reg;
    s_next.res_valid = 1'b0;
    s_next.res_wr = 1'b0;
    s_next.pc_load = 1'b0;
    s_next.trap = 1'b0;
    s_next.rdata = 32'h0;
    ev = '0;
    ev_clr = '0;
    shl_t = {32'h0, op_dst} << op_count;
    shr_t = 64'($signed({op_dst, 32'h0}) >>> op_count);
    bit_sel = 32'h1 << op_count[4:0];
    if (go) begin
      s_next.res_valid = 1'b1;
      ev[EV_DONE] = 1'b1;
      unique case (op)
        OP_AND_IMM: begin
          s_next.res_data = op_src & op_dst;
          s_next.res_wr = 1'b1;
          s_next.sw[FL_N] = s_next.res_data[31];
          s_next.sw[FL_Z] = (s_next.res_data == 32'h0);
          s_next.sw[FL_V] = 1'b0;
          s_next.sw[FL_C] = 1'b0;
        end
        OP_AND_FLAGS: begin
          s_next.sw[FLAGS_W-1:0] = s_reg.sw[FLAGS_W-1:0] & op_src[FLAGS_W-1:0];
        end
        OP_AND_STATUS: begin
          if (s_reg.sw[SUPER_BIT]) begin
            s_next.sw = s_reg.sw & op_src[15:0];
          end else begin
            s_next.trap = 1'b1;
            ev[EV_TRAP] = 1'b1;
          end
        end
        OP_SHIFT_LEFT: begin
          s_next.res_data = shl_t[31:0];
          s_next.res_wr = 1'b1;
          s_next.sw[FL_N] = shl_t[31];
          s_next.sw[FL_Z] = (shl_t[31:0] == 32'h0);
          s_next.sw[FL_V] = (op_count != 6'h0) &&
            (32'($signed(shl_t[31:0]) >>> op_count) != op_dst);
          s_next.sw[FL_C] = (op_count != 6'h0) && shl_t[32];
          if (op_count != 6'h0) begin
            s_next.sw[FL_X] = shl_t[32];
          end
        end
        OP_SHIFT_RIGHT: begin
          s_next.res_data = shr_t[63:32];
          s_next.res_wr = 1'b1;
          s_next.sw[FL_N] = shr_t[63];
          s_next.sw[FL_Z] = (shr_t[63:32] == 32'h0);
          s_next.sw[FL_V] = 1'b0;
          s_next.sw[FL_C] = shr_t[31];
          if (op_count != 6'h0) begin
            s_next.sw[FL_X] = shr_t[31];
          end
        end
        OP_BRANCH: begin
          if (cond_true) begin
            s_next.pc_load = 1'b1;
            s_next.pc_next = op_pc + op_disp;
            ev[EV_BRANCH] = 1'b1;
          end
        end
        OP_BIT_INVERT: begin
          // inverse bit to zero, then flip
          s_next.sw[FL_Z] = ~|(op_dst & bit_sel);
          s_next.res_data = op_dst ^ bit_sel;
          s_next.res_wr = 1'b1;
        end
        OP_FIELD_INVERT: begin
          s_next.res_data = op_dst ^ fld.mask;
          s_next.res_wr = 1'b1;
          s_next.sw[FL_N] = fld.ext_s[31];
          s_next.sw[FL_Z] = (fld.ext_u == 32'h0);
          s_next.sw[FL_V] = 1'b0;
          s_next.sw[FL_C] = 1'b0;
        end
        OP_FIELD_EXT_S, OP_FIELD_EXT_U: begin
          s_next.res_data = (op == OP_FIELD_EXT_S) ? fld.ext_s : fld.ext_u;
          s_next.res_wr = 1'b1;
          s_next.sw[FL_N] = fld.ext_s[31];
          s_next.sw[FL_Z] = (fld.ext_u == 32'h0);
          s_next.sw[FL_V] = 1'b0;
          s_next.sw[FL_C] = 1'b0;
        end
        default: begin
          s_next.res_valid = 1'b0;
          ev[EV_DONE] = 1'b0;
        end
      endcase
    end
    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_CTRL: s_next.ctrl_en = reg_wdata[CTRL_EN_BIT];
        OFS_EV_EN: s_next.ev_en = reg_wdata[EV_W-1:0];
        OFS_EV_CLR: ev_clr = reg_wdata[EV_W-1:0];
        default: s_next.ctrl_en = s_next.ctrl_en;
      endcase
    end
    // register reads, data stand one cycle
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CTRL: s_next.rdata = {31'h0, s_reg.ctrl_en};
        OFS_EV_STAT: s_next.rdata = {29'h0, s_reg.ev_stat};
        OFS_EV_EN: s_next.rdata = {29'h0, s_reg.ev_en};
        OFS_STATUS_WORD: s_next.rdata = {16'h0, s_reg.sw};
        default: s_next.rdata = 32'h0;
      endcase
    end
    // sticky events, a new event wins over a clear
    s_next.ev_stat = (s_reg.ev_stat & ~ev_clr) | ev;
    s_next.irq = |(s_next.ev_stat & s_next.ev_en);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{ctrl_en: CTRL_EN_RST, sw: STATUS_WORD_RST, ev_stat: EV_RST,
        ev_en: EV_RST, res_valid: 1'b0, res_wr: 1'b0, res_data: 32'h0,
        pc_load: 1'b0, pc_next: 32'h0, trap: 1'b0, rdata: 32'h0, irq: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign res_valid = s_reg.res_valid;
  assign res_wr = s_reg.res_wr;
  assign res_data = s_reg.res_data;
  assign pc_load = s_reg.pc_load;
  assign pc_next = s_reg.pc_next;
  assign trap = s_reg.trap;
  assign status_word = s_reg.sw;
  assign reg_rdata = s_reg.rdata;
  assign irq = s_reg.irq;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_and_imm_result: assert property (go && op == OP_AND_IMM |=>
    res_wr && res_data == ($past(op_dst) & $past(op_src)))
    else $error("and_immediate result wrong");
  a_status_priv_trap: assert property (go && op == OP_AND_STATUS &&
    !status_word[SUPER_BIT] |=> trap && $stable(status_word))
    else $error("user and to status_word not trapped");
  a_status_priv_and: assert property (go && op == OP_AND_STATUS &&
    status_word[SUPER_BIT] |=> !trap &&
    status_word == ($past(status_word) & $past(op_src[15:0])))
    else $error("supervisor and to status_word wrong");
  a_shift_left_val: assert property (go && op == OP_SHIFT_LEFT |=>
    res_data == 32'($past(op_dst) << $past(op_count)))
    else $error("shift left wrong");
  a_shift_right_val: assert property (go && op == OP_SHIFT_RIGHT |=>
    res_data == 32'($signed($past(op_dst)) >>> $past(op_count)))
    else $error("shift right wrong");
  a_branch_pc_load: assert property (go && op == OP_BRANCH |=>
    pc_load == $past(cond_true) && (!pc_load || pc_next == $past(op_pc) + $past(op_disp)))
    else $error("branch pc load wrong");
  a_bit_invert_z: assert property (go && op == OP_BIT_INVERT |=>
    status_word[FL_Z] == ~$past(op_dst[op_count[4:0]]) &&
    res_data == ($past(op_dst) ^ (32'h1 << $past(op_count[4:0]))))
    else $error("bit test invert wrong");
  a_field_keep_rest: assert property (go && op == OP_FIELD_INVERT |=>
    (res_data ^ $past(op_dst)) == $past(fld.mask) && res_data != $past(op_dst))
    else $error("field invert touched wrong bits");
  a_field_extract: assert property (go && op == OP_FIELD_EXT_U |=>
    res_data == $past(fld.ext_u) && res_wr)
    else $error("field extract wrong");
  a_logic_flags: assert property (go && op == OP_AND_IMM |=>
    status_word[FL_V:FL_C] == 2'h0 && status_word[FL_Z] == (res_data == 32'h0))
    else $error("logic flags wrong");
  a_irq_level: assert property (irq == |(s_reg.ev_stat & s_reg.ev_en))
    else $error("irq level wrong");
  a_bit_invert_keep: assert property (go && op == OP_BIT_INVERT |=>
    ((status_word ^ $past(status_word)) & ~(16'h1 << FL_Z)) == 16'h0)
    else $error("bit test invert touched other flags");
  a_field_invert_z: assert property (go && op == OP_FIELD_INVERT |=>
    res_wr && status_word[FL_Z] == (($past(op_dst) & $past(fld.mask)) == 32'h0))
    else $error("field invert zero flag wrong");
  a_field_ext_sign: assert property (go && op == OP_FIELD_EXT_S |=>
    res_wr && res_data == $past(fld.ext_s))
    else $error("signed field extract wrong");
  a_branch_target_hold: assert property (go && op == OP_BRANCH && !cond_true |=>
    !pc_load && $stable(pc_next))
    else $error("untaken branch moved pc target");
  a_branch_quiet: assert property (go && op == OP_BRANCH |=>
    !res_wr && $stable(status_word))
    else $error("branch wrote data or flags");
  a_user_trap_event: assert property (go && op == OP_AND_STATUS &&
    !status_word[SUPER_BIT] |=> s_reg.ev_stat[EV_TRAP])
    else $error("trap event not recorded");
  a_shift_left_zero: assert property (go && op == OP_SHIFT_LEFT && op_count == 6'h0 |=>
    res_data == $past(op_dst) && !status_word[FL_C])
    else $error("zero count shift changed data");
  a_and_imm_neg: assert property (go && op == OP_AND_IMM |=>
    status_word[FL_N] == res_data[31])
    else $error("and_immediate negative flag wrong");
  a_event_sticky: assert property (s_reg.ev_stat[EV_DONE] &&
    !(reg_wr && reg_addr == OFS_EV_CLR) |=> s_reg.ev_stat[EV_DONE])
    else $error("done event lost without clear");
  a_idle_quiet: assert property (!go |=>
    !res_valid && !res_wr && !pc_load && !trap)
    else $error("answer without request");

  c_branch_taken: cover property (go && op == OP_BRANCH ##1 pc_load);
  c_user_trap: cover property (go && op == OP_AND_STATUS ##1 trap);
  c_field_extract: cover property (go && op == OP_FIELD_EXT_S ##1 res_valid);
  c_irq_raised: cover property (!irq ##1 irq);
endmodule // ilb_core
`default_nettype wire

// >>> core/ilb_pkg.sv
package ilb_pkg;
  // register bus
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EV_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EV_EN = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EV_CLR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS_WORD = 8'h10;
  // control bits
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  // events
  localparam int EV_W = 3;
  localparam int EV_DONE = 0;
  localparam int EV_TRAP = 1;
  localparam int EV_BRANCH = 2;
  localparam logic [EV_W-1:0] EV_RST = 3'h0;
  // status word layout, condition_flags in the low bits
  localparam logic [15:0] STATUS_WORD_RST = 16'h2700;
  localparam int SUPER_BIT = 13;
  localparam int FL_X = 4;
  localparam int FL_N = 3;
  localparam int FL_Z = 2;
  localparam int FL_V = 1;
  localparam int FL_C = 0;
  localparam int FLAGS_W = 5;

  typedef enum logic [9:0] {
    OP_AND_IMM = 10'h001,
    OP_AND_FLAGS = 10'h002,
    OP_AND_STATUS = 10'h004,
    OP_SHIFT_LEFT = 10'h008,
    OP_SHIFT_RIGHT = 10'h010,
    OP_BRANCH = 10'h020,
    OP_BIT_INVERT = 10'h040,
    OP_FIELD_INVERT = 10'h080,
    OP_FIELD_EXT_S = 10'h100,
    OP_FIELD_EXT_U = 10'h200
  } ilb_op_e;
endpackage

// >>> core/ilb_fld_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ilb_fld_if;
  logic [31:0] data;
  logic [4:0] offset;
  logic [4:0] width;
  logic [31:0] mask;
  logic [31:0] ext_u;
  logic [31:0] ext_s;
  modport req (output data, output offset, output width, input mask, input ext_u, input ext_s);
  modport unit (input data, input offset, input width, output mask, output ext_u, output ext_s);
endinterface
`default_nettype wire

// >>> core/ilb_field_unit.sv
`timescale 1ns/10ps
`default_nettype none
module ilb_field_unit (
  ilb_fld_if.unit fld
);
  // rotate left through a doubled word
  function automatic logic [31:0] ilb_rotl(input logic [31:0] v, input logic [4:0] n);
    logic [63:0] d;
    d = {v, v} << n;
    return d[63:32];
  endfunction

  logic [5:0] w;
  logic [5:0] rsh;
  logic [31:0] top;
  logic [31:0] top_mask;

  always_comb begin
    // width 0 means a full 32-bit field
    w = (fld.width == 5'h00) ? 6'h20 : {1'b0, fld.width};
    rsh = 6'h20 - w;
    top = ilb_rotl(fld.data, fld.offset);
    top_mask = ~(32'hffffffff >> w);
    fld.ext_u = top >> rsh;
    fld.ext_s = 32'($signed(top) >>> rsh);
    // field mask rotated back into place, offset counted from the msb
    fld.mask = ilb_rotl(top_mask, 5'(6'h20 - {1'b0, fld.offset}));
  end
endmodule // ilb_field_unit
`default_nettype wire

// >>> core/ilb_cond_eval.sv
`timescale 1ns/10ps
`default_nettype none
module ilb_cond_eval (
  // condition code and flags n z v c
  input wire logic [3:0] cond,
  input wire logic [3:0] nzvc,
  // result
  output logic taken
);
  logic n, z, v, c;
  always_comb begin
    {n, z, v, c} = nzvc;
    unique case (cond)
      4'h0: taken = 1'b1;
      4'h1: taken = 1'b0;
      4'h2: taken = ~c & ~z;
      4'h3: taken = c | z;
      4'h4: taken = ~c;
      4'h5: taken = c;
      4'h6: taken = ~z;
      4'h7: taken = z;
      4'h8: taken = ~v;
      4'h9: taken = v;
      4'ha: taken = ~n;
      4'hb: taken = n;
      4'hc: taken = ~(n ^ v);
      4'hd: taken = n ^ v;
      4'he: taken = ~z & ~(n ^ v);
      4'hf: taken = z | (n ^ v);
    endcase
  end
endmodule // ilb_cond_eval
`default_nettype wire

// >>> sim/ilb_rf_model.sv
`timescale 1ns/10ps
`default_nettype none
module ilb_rf_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // write-back from the datapath
  input wire logic res_wr,
  input wire logic [31:0] res_data,
  // register file contents
  output logic [31:0] dreg
);
  // data_register takes each write-back
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dreg <= 32'h0;
    end else if (res_wr) begin
      dreg <= res_data;
    end
  end
endmodule // ilb_rf_model
`default_nettype wire

// >>> sim/integer_logic_bitfield_ops_tb.sv
`timescale 1ns/10ps
`default_nettype none
module integer_logic_bitfield_ops_tb;
  import ilb_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  ilb_op_e op = OP_AND_IMM;
  logic [31:0] op_dst = 32'h0, op_src = 32'h0, op_pc = 32'h0, op_disp = 32'h0;
  logic [5:0] op_count = 6'h0;
  logic [3:0] op_cond = 4'h0;
  logic [4:0] op_offset = 5'h0, op_width = 5'h0;
  logic [ADDR_W-1:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic res_valid, res_wr, pc_load, trap, irq;
  logic [31:0] res_data, pc_next, reg_rdata, dreg;
  logic [15:0] status_word;
  int errors = 0, checks = 0, seed = 55160, cyc = 0, k;
  ilb_op_e ops [8] = '{OP_AND_IMM, OP_AND_FLAGS, OP_SHIFT_LEFT, OP_SHIFT_RIGHT,
    OP_BIT_INVERT, OP_FIELD_INVERT, OP_FIELD_EXT_S, OP_FIELD_EXT_U};
  logic [31:0] d, s, e, pcv, dsp, m;
  logic [5:0] cnt;
  logic [3:0] cnd, f;
  logic [4:0] ofs, wid;
  logic fk, t;
  logic [15:0] sw;

  always #50 core_clk = ~core_clk;

  ilb_core uut (.core_clk, .rst_n, .op_valid, .op, .op_dst, .op_src, .op_count, .op_cond,
    .op_pc, .op_disp, .op_offset, .op_width, .res_valid, .res_wr, .res_data, .pc_load,
    .pc_next, .trap, .status_word, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);

  ilb_rf_model rf (.core_clk, .rst_n, .res_wr, .res_data, .dreg);

  function automatic logic [31:0] fmask(input logic [4:0] o, w);
    logic [31:0] r;
    r = 32'h0;
    for (int j = 0; j < ((w == 0) ? 32 : w); j++) r[31 - ((o + j) % 32)] = 1'b1;
    return r;
  endfunction

  function automatic logic [31:0] fext(input logic [31:0] v, input logic [4:0] o, w,
    input logic sg);
    logic [31:0] r;
    int n;
    n = (w == 0) ? 32 : w;
    r = 32'h0;
    for (int j = 0; j < n; j++) r = {r[30:0], v[31 - ((o + j) % 32)]};
    if (sg && n < 32 && v[31 - o]) r = r | (32'hffffffff << n);
    return r;
  endfunction

  function automatic logic cok(input logic [3:0] c, input logic [3:0] q);
    logic n, z, v, cy;
    logic [15:0] tt;
    {n, z, v, cy} = q;
    tt = {z | (n ^ v), ~z & ~(n ^ v), n ^ v, ~(n ^ v), n, ~n, v, ~v, z, ~z, cy, ~cy,
      cy | z, ~cy & ~z, 1'b0, 1'b1};
    return tt[c];
  endfunction

  task automatic chk(input logic [31:0] g, x);
    checks++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, x);
    end
  endtask

  task automatic stop_test;
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic go(input ilb_op_e o, input logic [31:0] a, b);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op <= o;
    op_dst <= a;
    op_src <= b;
    op_count <= cnt;
    op_cond <= cnd;
    op_pc <= pcv;
    op_disp <= dsp;
    op_offset <= ofs;
    op_width <= wid;
    @(posedge core_clk);
    op_valid <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, x);
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk(status_word, STATUS_WORD_RST);
    rd(OFS_CTRL, 32'h1);
    rd(OFS_EV_EN, 32'h0);
    rd(8'h20, 32'h0);
    fk = 1'b1;
    f = 4'h0;
    for (int i = 0; i < 80; i++) begin
      d = $random(seed);
      s = $random(seed);
      pcv = $random(seed);
      dsp = $random(seed);
      {cnd, cnt, ofs, wid} = 20'($random(seed));
      k = {$random(seed)} % 8;
      // first rounds walk each of the eight ops in ops with boundary counts
      if (i < 16) k = i % 8;
      if (i < 8) {cnt, wid, s} = 43'h0;
      if (i >= 8 && i < 16) {cnt, ofs} = 11'h7ff;
      if (k >= 5) s = d;
      m = fmask(ofs, wid);
      case (k)
        0: e = d & s;
        2: e = d << cnt;
        3: e = $signed(d) >>> cnt;
        4: e = d ^ (32'h1 << cnt[4:0]);
        5: e = d ^ m;
        6: e = fext(d, ofs, wid, 1'b1);
        7: e = fext(d, ofs, wid, 1'b0);
        default: e = 32'h0;
      endcase
      go(ops[k], d, s);
      chk(res_valid, 32'h1);
      if (k != 1) begin
        chk(res_wr, 32'h1);
        chk(res_data, e);
        @(posedge core_clk);
        #1;
        chk(dreg, e);
      end
      case (k)
        0: f = {e[31], e == 32'h0, 2'b00};
        1: f = f & s[3:0];
        4: f[2] = ~d[cnt[4:0]];
        5, 6, 7: f = {d[31 - ofs], (d & m) == 32'h0, 2'b00};
        default: fk = 1'b0;
      endcase
      if (k == 0 || k >= 5) fk = 1'b1;
      if (fk) begin
        chk(status_word[3:0], f);
        go(OP_BRANCH, d, s);
        t = cok(cnd, f);
        chk(pc_load, t);
        if (t) chk(pc_next, pcv + dsp);
      end
    end
    wr(OFS_EV_CLR, 32'h7);
    wr(OFS_EV_EN, 32'h7);
    rd(OFS_EV_STAT, 32'h0);
    chk(irq, 32'h0);
    go(OP_AND_IMM, 32'h1, 32'h1);
    chk(irq, 32'h1);
    rd(OFS_EV_STAT, 32'h1);
    wr(OFS_EV_EN, 32'h0);
    rd(OFS_EV_EN, 32'h0);
    chk(irq, 32'h0);
    wr(OFS_EV_EN, 32'h7);
    wr(OFS_EV_CLR, 32'h1);
    rd(OFS_EV_STAT, 32'h0);
    chk(irq, 32'h0);
    wr(OFS_CTRL, 32'h0);
    go(OP_AND_IMM, 32'h0, 32'h0);
    chk(res_valid, 32'h0);
    wr(OFS_CTRL, 32'h1);
    rd(OFS_CTRL, 32'h1);
    go(ilb_op_e'(10'h003), 32'h0, 32'h0);
    chk(res_valid, 32'h0);
    // supervisor and, then drop to user, then a refused and
    s = $random(seed);
    s = (s | 32'h2000) & 32'hffffffef;
    sw = STATUS_WORD_RST & s[15:0];
    go(OP_AND_STATUS, 32'h0, s);
    chk(trap, 32'h0);
    chk(status_word, sw);
    rd(OFS_STATUS_WORD, {16'h0, sw});
    s[13] = 1'b0;
    sw = sw & s[15:0];
    go(OP_AND_STATUS, 32'h0, s);
    chk(status_word, sw);
    go(OP_AND_STATUS, 32'h0, 32'hffff);
    chk(trap, 32'h1);
    chk(status_word, sw);
    rd(OFS_EV_STAT, 32'h3);
    stop_test();
  end
endmodule // integer_logic_bitfield_ops_tb
`default_nettype wire
